// [design/gnss_nmea_time_receiver.sv]
// NMEA sentence receiver: position, fix quality and epoch seconds tied to the pulse edge.
// Assumes an AXI4-Lite master, an RS232 line and a once-per-second pulse, both asynchronous.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "gnss_consts.svh"
module gnss_nmea_time_receiver #(
  parameter int unsigned DIV_4800 = `BAUD_DIV(4800)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  input wire logic pps,
  output logic [31:0] lat_fixed_point,
  output logic [31:0] lon_fixed_point,
  output logic [1:0] fix_quality,
  output logic [31:0] epoch_seconds,
  output logic seq_error
);
  import gnss_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] baud_sel_r;
  logic en_r;
  logic [31:0] pos_rate_r, other_rate_r;
  logic seq_err_r, cks_err_r, ovr_err_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_mux;
  logic rd_hit, wr_hit, wr_go, rd_go;
  logic [15:0] bit_div;
  logic overrun;
  logic pps_m_r, pps_s_r, pps_d_r, pps_rise;
  logic [31:0] tick_r, edge_pend_r, stamp_r;
  logic edge_armed_r, tval_r;
  parse_state_t state_r;
  logic [7:0] c, xor_r;
  logic [3:0] field_r, pos_r, ck_hi_r, qual_r;
  logic fire, is_dig, fe, ch, commit, ck_ok, talker_ok, good;
  logic [39:0] id_r;
  sent_kind_t kind;
  logic [23:0] tim_r, dat_r;
  logic [7:0] deg_r;
  logic [3:0] mt_r, mo_r;
  logic [16:0] frac_r;
  logic [2:0] fcnt_r;
  logic in_frac_r, south_r, west_r;
  logic [31:0] lat_abs_r, lon_abs_r, lat_r, lon_r, epoch_r;
  logic [1:0] fixq_r, seq_r;
  logic seq_bad_r, seq_arm_r, seq_evt;

  byte_stream_if #(.W(8)) rx_bs ();
  byte_stream_if #(.W(8)) fifo_bs ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        old[8*i +: 8] = nw[8*i +: 8];
    return old;
  endfunction : merge

  function automatic logic [3:0] hexval(input logic [7:0] h);
    return (h >= "A") ? 4'(h[3:0] + 4'h9) : h[3:0];
  endfunction : hexval

  // Minutes become 1E-7 degree by *5/3; the divide is an exact reciprocal multiply
  function automatic logic [31:0] coord(input logic [7:0] dg, input logic [3:0] a, input logic [3:0] b,
                                        input logic [16:0] f, input logic [2:0] n);
    logic [31:0] fs, mf;
    logic [63:0] q;
    case (n)
      3'h0: fs = 32'h0;
      3'h1: fs = 32'(f) * 32'h0000_2710;
      3'h2: fs = 32'(f) * 32'h0000_03E8;
      3'h3: fs = 32'(f) * 32'h0000_0064;
      3'h4: fs = 32'(f) * 32'h0000_000A;
      default: fs = 32'(f);
    endcase
    mf = (32'(a) * 32'h0000_000A + 32'(b)) * 32'h0001_86A0 + fs;
    q = 64'(mf * 32'h0000_0005) * 64'h0000_0000_AAAA_AAAB;
    return 32'(dg) * 32'h0098_9680 + 32'(q >> 33);
  endfunction : coord

  function automatic logic [31:0] epoch(input logic [23:0] t, input logic [23:0] d);
    logic [31:0] dd, mo, yy, cum, days, sod;
    dd = 32'(d[23:20]) * 32'h0000_000A + 32'(d[19:16]);
    mo = 32'(d[15:12]) * 32'h0000_000A + 32'(d[11:8]);
    yy = 32'(d[7:4]) * 32'h0000_000A + 32'(d[3:0]);
    case (mo[3:0])
      4'h2: cum = 32'h0000_001F;
      4'h3: cum = 32'h0000_003B;
      4'h4: cum = 32'h0000_005A;
      4'h5: cum = 32'h0000_0078;
      4'h6: cum = 32'h0000_0097;
      4'h7: cum = 32'h0000_00B5;
      4'h8: cum = 32'h0000_00D4;
      4'h9: cum = 32'h0000_00F3;
      4'hA: cum = 32'h0000_0111;
      4'hB: cum = 32'h0000_0130;
      4'hC: cum = 32'h0000_014E;
      default: cum = 32'h0;
    endcase
    // Two-digit years taken as 2000..2099
    days = `DAYS_1970_TO_2000 + yy * 32'h0000_016D + ((yy + 32'h3) >> 2) + cum + dd - 32'h1
         + ((yy[1:0] == 2'h0 && mo > 32'h2) ? 32'h1 : 32'h0);
    sod = (32'(t[23:20]) * 32'hA + 32'(t[19:16])) * 32'h0000_0E10
        + (32'(t[15:12]) * 32'hA + 32'(t[11:8])) * 32'h0000_003C
        + 32'(t[7:4]) * 32'hA + 32'(t[3:0]);
    return days * `SEC_PER_DAY + sod;
  endfunction : epoch

  // ----------------------------------------
  // Serial path
  // ----------------------------------------
  always_comb
  begin
    case (baud_sel_r)
      3'h0: bit_div = DIV_4800[15:0];
      3'h1: bit_div = 16'(`BAUD_DIV(9600));
      3'h2: bit_div = 16'(`BAUD_DIV(19200));
      3'h3: bit_div = 16'(`BAUD_DIV(38400));
      3'h4: bit_div = 16'(`BAUD_DIV(57600));
      default: bit_div = 16'(`BAUD_DIV(115200));
    endcase
  end

  serial_byte_rx u_rx (.aclk(aclk), .aresetn(aresetn), .rxd(rxd), .bit_div(bit_div), .out(rx_bs),
                       .overrun(overrun));
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (.aclk(aclk), .aresetn(aresetn), .wr(rx_bs),
                                                     .rd(fifo_bs));

  // Parsing stalls while disabled, so the FIFO fills and then overruns
  assign fifo_bs.ready = en_r;
  assign c = fifo_bs.data;
  assign fire = fifo_bs.valid & en_r;
  assign is_dig = (c >= "0") && (c <= "9");
  assign fe = fire && state_r == P_BODY && (c == "," || c == "*");
  assign ch = fire && state_r == P_BODY && c != "," && c != "*" && c != "$";
  assign commit = fire && state_r == P_CK_LO && c != "$";
  assign ck_ok = ({ck_hi_r, hexval(c)} == xor_r);
  assign talker_ok = id_r[39:32] == "G" && (id_r[31:24] inside {"A", "B", "I", "L", "N", "P", "Q"});
  assign kind = (id_r[23:0] == "RMC") ? S_RMC : (id_r[23:0] == "GGA") ? S_GGA :
                (id_r[23:0] == "GSA") ? S_GSA : S_NONE;
  assign good = commit & ck_ok & talker_ok & (kind != S_NONE);

  // ----------------------------------------
  // Sentence framing
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= P_IDLE;
      xor_r <= 8'h00;
      field_r <= 4'h0;
      pos_r <= 4'h0;
      ck_hi_r <= 4'h0;
    end
    else if (fire)
    begin
      if (c == "$")
      begin
        state_r <= P_BODY;
        xor_r <= 8'h00;
        field_r <= 4'h0;
        pos_r <= 4'h0;
      end
      else
        unique case (state_r)
          P_IDLE: ;
          P_BODY:
            if (c == "*")
              state_r <= P_CK_HI;
            else
            begin
              xor_r <= xor_r ^ c;
              if (c == ",")
              begin
                field_r <= (field_r == 4'hF) ? field_r : field_r + 4'h1;
                pos_r <= 4'h0;
              end
              else if (pos_r != 4'hF)
                pos_r <= pos_r + 4'h1;
            end
          P_CK_HI:
          begin
            ck_hi_r <= hexval(c);
            state_r <= P_CK_LO;
          end
          P_CK_LO: state_r <= P_IDLE;
        endcase
    end
  end

  // ----------------------------------------
  // Field capture
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (fire && c == "$"))
    begin
      id_r <= 40'h0;
      tim_r <= 24'h0;
      dat_r <= 24'h0;
      {deg_r, mt_r, mo_r, frac_r, fcnt_r, in_frac_r} <= '0;
      {south_r, west_r, qual_r, lat_abs_r, lon_abs_r} <= '0;
    end
    else if (ch)
    begin
      if (field_r == 4'h0 && pos_r < 4'h5)
        id_r <= {id_r[31:0], c};
      if (field_r == 4'h1 && is_dig && pos_r < 4'h6)
        tim_r <= {tim_r[19:0], c[3:0]};
      if (kind == S_RMC && field_r == 4'h9 && is_dig && pos_r < 4'h6)
        dat_r <= {dat_r[19:0], c[3:0]};
      if (kind == S_GGA && (field_r == 4'h2 || field_r == 4'h4))
      begin
        if (c == ".")
          in_frac_r <= 1'b1;
        else if (is_dig && in_frac_r && fcnt_r < 3'h5)
        begin
          frac_r <= 17'(frac_r * 17'h0000A + 17'(c[3:0]));
          fcnt_r <= fcnt_r + 3'h1;
        end
        else if (is_dig && !in_frac_r)
        begin
          deg_r <= 8'(deg_r * 8'h0A + 8'(mt_r));
          mt_r <= mo_r;
          mo_r <= c[3:0];
        end
      end
      if (kind == S_GGA && field_r == 4'h3)
        south_r <= (c == "S");
      if (kind == S_GGA && field_r == 4'h5)
        west_r <= (c == "W");
      if (kind == S_GGA && field_r == 4'h6 && is_dig)
        qual_r <= c[3:0];
    end
    else if (fe)
    begin
      if (kind == S_GGA && field_r == 4'h2)
        lat_abs_r <= coord(deg_r, mt_r, mo_r, frac_r, fcnt_r);
      if (kind == S_GGA && field_r == 4'h4)
        lon_abs_r <= coord(deg_r, mt_r, mo_r, frac_r, fcnt_r);
      {deg_r, mt_r, mo_r, frac_r, fcnt_r, in_frac_r} <= '0;
    end
  end

  // ----------------------------------------
  // Pulse edge and outputs
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    pps_m_r <= pps;
    pps_s_r <= pps_m_r;
    pps_d_r <= pps_s_r;
  end
  assign pps_rise = pps_s_r & ~pps_d_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_r <= 32'h0;
      edge_pend_r <= 32'h0;
      edge_armed_r <= 1'b0;
    end
    else
    begin
      tick_r <= tick_r + 32'h1;
      if (pps_rise)
      begin
        edge_pend_r <= tick_r;
        edge_armed_r <= 1'b1;
      end
      else if (good && kind == S_RMC)
        edge_armed_r <= 1'b0;
    end
  end

  // Bad sentences never reach here, so held values stay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {epoch_r, stamp_r, lat_r, lon_r} <= '0;
      fixq_r <= 2'h0;
      tval_r <= 1'b0;
    end
    else if (good)
    begin
      if (kind == S_RMC)
      begin
        epoch_r <= epoch(tim_r, dat_r);
        stamp_r <= edge_pend_r;
        tval_r <= edge_armed_r;
      end
      if (kind == S_GGA)
      begin
        lat_r <= south_r ? -lat_abs_r : lat_abs_r;
        lon_r <= west_r ? -lon_abs_r : lon_abs_r;
        fixq_r <= (qual_r == 4'h0) ? 2'h0 : (qual_r == 4'h2) ? 2'h2 : 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Sentence order
  // ----------------------------------------
  // The first edge after reset only arms the check
  assign seq_evt = pps_rise && seq_arm_r && (seq_r != 2'h3 || seq_bad_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_r <= 2'h0;
      seq_bad_r <= 1'b0;
      seq_arm_r <= 1'b0;
    end
    else if (pps_rise)
    begin
      seq_r <= 2'h0;
      seq_bad_r <= 1'b0;
      seq_arm_r <= 1'b1;
    end
    else if (good)
    begin
      // Unknown types are ignored; only known ones out of turn count
      if ((seq_r == 2'h0 && kind == S_RMC) || (seq_r == 2'h1 && kind == S_GGA) ||
          (seq_r == 2'h2 && kind == S_GSA))
        seq_r <= seq_r + 2'h1;
      else
        seq_bad_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  assign wr_go = awvalid & wvalid & ~bvalid_r;
  assign rd_go = arvalid & ~rvalid_r;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;
  assign wr_hit = awaddr inside {`A_CTRL, `A_STATUS, `A_POS_RATE, `A_OTHER_RATE};
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_sel_r <= 3'(`CTRL_RESET);
      en_r <= 1'(`CTRL_RESET >> `CTRL_EN_BIT);
      pos_rate_r <= 32'h0;
      other_rate_r <= 32'h0;
    end
    else if (wr_go)
    begin
      if (awaddr == `A_CTRL && wstrb[0])
      begin
        baud_sel_r <= wdata[2:0];
        en_r <= wdata[`CTRL_EN_BIT];
      end
      if (awaddr == `A_POS_RATE)
        pos_rate_r <= merge(pos_rate_r, wdata, wstrb);
      if (awaddr == `A_OTHER_RATE)
        other_rate_r <= merge(other_rate_r, wdata, wstrb);
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {seq_err_r, cks_err_r, ovr_err_r} <= 3'h0;
    else
    begin
      seq_err_r <= seq_evt | (seq_err_r & ~(wr_go && awaddr == `A_STATUS && wstrb[1] && wdata[`ST_SEQ_BIT]));
      cks_err_r <= (commit & ~ck_ok) | (cks_err_r & ~(wr_go && awaddr == `A_STATUS && wstrb[1] &&
                                                     wdata[`ST_CKS_BIT]));
      ovr_err_r <= overrun | (ovr_err_r & ~(wr_go && awaddr == `A_STATUS && wstrb[1] && wdata[`ST_OVR_BIT]));
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0;
    case (araddr)
      `A_CTRL: rd_mux = {28'h0, en_r, baud_sel_r};
      `A_STATUS:
      begin
        rd_mux[1:0] = fixq_r;
        rd_mux[`ST_TVAL_BIT] = tval_r;
        rd_mux[`ST_SEQ_BIT] = seq_err_r;
        rd_mux[`ST_CKS_BIT] = cks_err_r;
        rd_mux[`ST_OVR_BIT] = ovr_err_r;
        rd_mux[`ST_RATE_BIT] = other_rate_r < pos_rate_r;
      end
      `A_LAT: rd_mux = lat_r;
      `A_LON: rd_mux = lon_r;
      `A_EPOCH: rd_mux = epoch_r;
      `A_STAMP: rd_mux = stamp_r;
      `A_POS_RATE: rd_mux = pos_rate_r;
      `A_OTHER_RATE: rd_mux = other_rate_r;
      `A_FASTEST: rd_mux = other_rate_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
      if (rd_go)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        rdata_r <= rd_mux;
      end
      else if (rready)
        rvalid_r <= 1'b0;
    end
  end

  assign lat_fixed_point = lat_r;
  assign lon_fixed_point = lon_r;
  assign fix_quality = fixq_r;
  assign epoch_seconds = epoch_r;
  assign seq_error = seq_err_r;
endmodule : gnss_nmea_time_receiver

// [common/gnss_consts.svh]
// Offsets, field positions, reset values and timing counts of the NMEA time receiver.
// Assumes a 25 MHz system clock and 32-bit AXI4-Lite data.
`ifndef GNSS_CONSTS_SVH
`define GNSS_CONSTS_SVH
`define CLK_HZ 25000000
`define BAUD_DIV(b) (`CLK_HZ / (b))
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_LAT 8'h08
`define A_LON 8'h0C
`define A_EPOCH 8'h10
`define A_STAMP 8'h14
`define A_POS_RATE 8'h18
`define A_OTHER_RATE 8'h1C
`define A_FASTEST 8'h20
`define CTRL_EN_BIT 3
`define CTRL_RESET 32'h0000_0008
`define ST_TVAL_BIT 4
`define ST_SEQ_BIT 8
`define ST_CKS_BIT 9
`define ST_OVR_BIT 10
`define ST_RATE_BIT 12
`define DAYS_1970_TO_2000 32'h0000_2ACD
`define SEC_PER_DAY 32'h0001_5180
`define FIFO_DEPTH 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [common/gnss_pkg.sv]
// Types shared by the NMEA time receiver modules.
// Assumes nothing beyond a SystemVerilog compiler.
package gnss_pkg;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_BODY = 2'b01, P_CK_HI = 2'b10, P_CK_LO = 2'b11} parse_state_t;
  typedef enum logic [1:0] {S_NONE = 2'b00, S_RMC = 2'b01, S_GGA = 2'b10, S_GSA = 2'b11} sent_kind_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_t;
endpackage : gnss_pkg

// [common/byte_stream_if.sv]
// Valid/ready byte stream between the receiver's own modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ns
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// [design/serial_byte_rx.sv]
// Asynchronous serial receiver, 8 data bits, 1 stop bit, no flow control.
// Assumes rxd idles high; bit_div is the clock count of one bit.
`timescale 1ns/1ns
module serial_byte_rx
  import gnss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rxd,
  input wire logic [15:0] bit_div,
  byte_stream_if.src out,
  output logic overrun
);
  rx_state_t state_r;
  logic rx_m_r, rx_s_r;
  logic [15:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic valid_r;

  always_ff @(posedge aclk)
  begin
    rx_m_r <= rxd;
    rx_s_r <= rx_m_r;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= RX_IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= 1'b0;
      unique case (state_r)
        RX_IDLE:
          if (!rx_s_r)
          begin
            state_r <= RX_START;
            cnt_r <= bit_div >> 1;
          end
        RX_START:
          if (cnt_r == 16'h0000)
          begin
            // Glitch shorter than half a bit is dropped
            state_r <= rx_s_r ? RX_IDLE : RX_DATA;
            cnt_r <= bit_div - 16'h0001;
            bit_r <= 3'h0;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        RX_DATA:
          if (cnt_r == 16'h0000)
          begin
            sh_r <= {rx_s_r, sh_r[7:1]};
            cnt_r <= bit_div - 16'h0001;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7)
              state_r <= RX_STOP;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        RX_STOP:
          if (cnt_r == 16'h0000)
          begin
            state_r <= RX_IDLE;
            valid_r <= rx_s_r;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
      endcase
    end
  end

  // No flow control on the line, so a refused byte is lost
  assign out.valid = valid_r;
  assign out.data = sh_r;
  assign overrun = valid_r & ~out.ready;
endmodule : serial_byte_rx

// [design/byte_fifo.sv]
// Synchronous FIFO with a registered read stage.
// Assumes both sides on one clock; WIDTH matches the interfaces.
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic [WIDTH-1:0] od_r;
  logic ov_r;
  logic full, empty, push, load;

  assign empty = (wp_r == rp_r);
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign push = wr.valid & ~full;
  assign load = ~empty & (~ov_r | rd.ready);
  assign wr.ready = ~full;
  assign rd.valid = ov_r;
  assign rd.data = od_r;

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= wr.data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (load)
      begin
        od_r <= mem[rp_r[AW-1:0]];
        rp_r <= rp_r + 1'b1;
        ov_r <= 1'b1;
      end
      else if (rd.ready)
        ov_r <= 1'b0;
    end
  end
endmodule : byte_fifo

// [verification/gnss_rx_checker.sv]
// Port assertions for the NMEA time receiver.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ns
module gnss_rx_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] fix_quality,
  input wire logic seq_error
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; awvalid && awready; endsequence
  sequence rd_take; arvalid && arready; endsequence
  aw_gate_a: assert property (awready |-> wvalid && !bvalid) else $error("aw taken alone");
  b_follow_a: assert property (wr_take |=> bvalid) else $error("no write answer");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b dropped");
  ar_gate_a: assert property (rvalid |-> !arready) else $error("read while busy");
  r_follow_a: assert property (rd_take |=> rvalid) else $error("no read answer");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r dropped");
  qual_code_a: assert property (fix_quality != 2'h3) else $error("bad quality");
  seq_sticky_a: assert property (seq_error && !awready |=> seq_error) else $error("seq lost");
endmodule : gnss_rx_checker
bind gnss_nmea_time_receiver gnss_rx_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .wvalid(wvalid), .awready(awready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .fix_quality(fix_quality),
  .seq_error(seq_error));

// [verification/gnss_source_model.sv]
// Behavioural satellite receiver: sentences on rxd, second pulse on pps.
// Assumes the bench calls its tasks; BIT is the clock count of one bit.
`timescale 1ns/1ns
module gnss_source_model #(
  parameter int BIT = 16
) (
  input wire logic aclk,
  output logic rxd,
  output logic pps
);
  initial
  begin
    rxd = 1'b1;
    pps = 1'b0;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  task automatic tx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i]; // Start, LSB first, one stop, no flow control
      repeat (BIT) @(posedge aclk);
    end
  endtask : tx
  task automatic sentence(input string s, input logic bad);
    logic [7:0] c;
    c = 8'h00;
    tx(8'h24);
    foreach (s[i])
    begin
      c = c ^ s[i];
      tx(s[i]);
    end
    c = c ^ {7'h00, bad};
    tx(8'h2A);
    tx(hx(c[7:4]));
    tx(hx(c[3:0]));
    tx(8'h0D);
    tx(8'h0A);
  endtask : sentence
  task automatic pulse;
    pps <= 1'b1;
    repeat (50) @(posedge aclk);
    pps <= 1'b0;
  endtask : pulse
endmodule : gnss_source_model

// [verification/gnss_nmea_time_receiver_tb.sv]
// Self-checking bench for the NMEA time receiver.
// Assumes the source model drives rxd and pps; DIV_4800 shortened to 16.
`timescale 1ns/1ns
`include "gnss_consts.svh"
module gnss_nmea_time_receiver_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rxd, pps, awready, bvalid, arready, rvalid, seq_error;
  logic wready;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, fq;
  logic [31:0] wdata, rdata, lat, lon, ep, d;
  int fails, compares, cyc;
  gnss_nmea_time_receiver #(.DIV_4800(16)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd), .pps(pps),
    .lat_fixed_point(lat), .lon_fixed_point(lon), .fix_quality(fq), .epoch_seconds(ep), .seq_error(seq_error));
  gnss_source_model #(.BIT(16)) src (.aclk(aclk), .rxd(rxd), .pps(pps));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Hang guard well above the roughly 33k cycles of traffic
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready is combinational, so look at it settled before the taking edge
    do @(negedge aclk); while (awready !== 1'b1);
    chk("wready", 32'h0000_0001, 32'(wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // Late bready keeps the response waiting a cycle
    @(posedge aclk);
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk("bresp", 32'(r), 32'(bresp));
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk("rresp", 32'(r), 32'(rresp));
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic t_regs;
    rd(`A_CTRL, `RESP_OKAY);
    chk("ctrl", `CTRL_RESET, d);
    wr(`A_CTRL, 32'h0000_000D, `RESP_OKAY);
    rd(`A_CTRL, `RESP_OKAY);
    chk("ctrl", 32'h0000_000D, d);
    wr(`A_CTRL, `CTRL_RESET, `RESP_OKAY);
    wr(8'h40, 32'h0000_0001, `RESP_SLVERR);
    rd(8'h40, `RESP_SLVERR);
    chk("unmapped", 32'h0000_0000, d);
    // Position faster than the rest, so only its exclusion gives the other rate
    wr(`A_POS_RATE, 32'h0000_0064, `RESP_OKAY);
    wr(`A_OTHER_RATE, 32'h0000_0032, `RESP_OKAY);
    rd(`A_FASTEST, `RESP_OKAY);
    chk("fastest", 32'h0000_0032, d);
    rd(`A_STATUS, `RESP_OKAY);
    chk("rate_err", 32'h0000_0001, 32'(d[`ST_RATE_BIT]));
  endtask : t_regs
  task automatic t_good;
    src.pulse();
    src.sentence("GPRMC,000010,A,,,,,,,010100", 1'b0);
    src.sentence("GNGGA,000010,1030.00000,S,02000.00000,E,2", 1'b0);
    src.sentence("GPVTG,,", 1'b0);
    src.sentence("GAGSA,A,3", 1'b0);
    repeat (20) @(posedge aclk);
    chk("lat", 32'hF9BD_D3C0, lat);
    chk("lon", 32'h0BEB_C200, lon);
    chk("quality", 32'h0000_0002, 32'(fq));
    chk("epoch", 32'h386D_438A, ep);
    src.pulse();
    repeat (10) @(posedge aclk);
    chk("seq", 32'h0000_0000, 32'(seq_error));
  endtask : t_good
  task automatic t_bad;
    src.sentence("GQRMC,000011,A,,,,,,,010100", 1'b0);
    src.sentence("GIGGA,000011,0000.00000,N,00000.00000,E,1", 1'b1);
    src.sentence("GLGSA,A,3", 1'b0);
    repeat (20) @(posedge aclk);
    chk("lat", 32'hF9BD_D3C0, lat);
    chk("quality", 32'h0000_0002, 32'(fq));
    chk("epoch", 32'h386D_438B, ep);
    rd(`A_STATUS, `RESP_OKAY);
    chk("cks_err", 32'h0000_0001, 32'(d[`ST_CKS_BIT]));
    chk("tval", 32'h0000_0001, 32'(d[`ST_TVAL_BIT]));
    src.pulse();
    repeat (10) @(posedge aclk);
    chk("seq", 32'h0000_0001, 32'(seq_error));
    wr(`A_STATUS, 32'h0000_0300, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("seq_clr", 32'h0000_0000, 32'(seq_error));
  endtask : t_bad
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_good();
    t_bad();
    results();
  end
endmodule : gnss_nmea_time_receiver_tb
